// [ssi_pkg.sv]
// ssi_pkg: constants, types and decode helpers for the serial shift-in block.
// assumes: a 32 ns link timebase clock and a 16-pin general-purpose port.
package ssi_pkg;

    localparam int unsigned NUM_PINS       = 16;
    localparam int unsigned PIN_SEL_W      = 4;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned BITS_W         = 5;
    localparam int unsigned CNT_W          = 9;

    // link timebase and pulse timing
    localparam int unsigned LCLK_PERIOD_NS = 32;
    localparam int unsigned PULSE_TIME_NS  = 14000;
    localparam int unsigned LOW_TIME_NS    = 1000;
    // least times, so round up to whole link cycles
    localparam int unsigned PULSE_CYCLES   =
        (PULSE_TIME_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS;
    localparam int unsigned LOW_CYCLES     =
        (LOW_TIME_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] PULSE_CNT_LAST =
        CNT_W'(PULSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] LOW_CNT_LAST   =
        CNT_W'(LOW_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_RESET      = 9'h000;

    // order and sampling selector
    localparam logic [1:0] MODE_MSB_FIRST_SAMPLE_EARLY = 2'h0;
    localparam logic [1:0] MODE_LSB_FIRST_SAMPLE_EARLY = 2'h1;
    localparam logic [1:0] MODE_MSB_FIRST_SAMPLE_LATE  = 2'h2;
    localparam logic [1:0] MODE_LSB_FIRST_SAMPLE_LATE  = 2'h3;
    localparam int unsigned MODE_LSB_POS  = 0;
    localparam int unsigned MODE_LATE_POS = 1;

    // bit count
    localparam logic [BITS_W-1:0] BITS_DEFAULT = 5'h08;
    localparam logic [BITS_W-1:0] BITS_MAX     = 5'h10;
    localparam logic [BITS_W-1:0] BITS_RESET   = 5'h00;

    // destination size codes
    localparam logic [1:0] DEST_BIT    = 2'h0;
    localparam logic [1:0] DEST_NIBBLE = 2'h1;
    localparam logic [1:0] DEST_BYTE   = 2'h2;
    localparam logic [1:0] DEST_WORD   = 2'h3;

    localparam logic [DATA_W-1:0]   DATA_RESET = 16'h0000;
    localparam logic [NUM_PINS-1:0] PINS_LOW   = 16'h0000;
    localparam logic [NUM_PINS-1:0] PINS_INPUT = 16'hffff;
    localparam logic [PIN_SEL_W-1:0] PIN_RESET = 4'h0;

    // link engine states
    typedef enum logic [5:0] {
        SSI_L_IDLE  = 6'h01,
        SSI_L_SETUP = 6'h02,
        SSI_L_BIT   = 6'h04,
        SSI_L_HIGH  = 6'h08,
        SSI_L_LOW   = 6'h10,
        SSI_L_DONE  = 6'h20
    } ssi_lstate_t;

    // zero asks for the default; anything past sixteen is held at sixteen
    function automatic logic [BITS_W-1:0] ssi_bits(
        input logic [BITS_W-1:0] req);
        logic [BITS_W-1:0] n;
        n = req;
        if (req == BITS_RESET) begin
            n = BITS_DEFAULT;
        end else if (req > BITS_MAX) begin
            n = BITS_MAX;
        end
        return n;
    endfunction

    // keeps only the bits the destination can hold
    function automatic logic [DATA_W-1:0] ssi_dest_mask(
        input logic [1:0] dest);
        logic [DATA_W-1:0] m;
        m = 16'hffff;
        case (dest)
            DEST_BIT:    m = 16'h0001;
            DEST_NIBBLE: m = 16'h000f;
            DEST_BYTE:   m = 16'h00ff;
            default:     m = 16'hffff;
        endcase
        return m;
    endfunction

endpackage

// [ssi_sync.sv]
// ssi_sync: two-flop level synchroniser, any width.
// assumes: each bit is a slow level; words must be held stable elsewhere.
`timescale 1ns/100ps
module ssi_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds the second stage only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule

// [ssi_event_rx.sv]
// ssi_event_rx: receives a toggle from another domain as a one-cycle pulse.
// assumes: the sender flips its toggle at most once per few receiver cycles.
`timescale 1ns/100ps
module ssi_event_rx (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_toggle,
    output logic      o_pulse
);

    logic tog_sync;
    logic tog_seen_reg;

    ssi_sync #(.WIDTH(1)) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_toggle),
        .o_sync  (tog_sync)
    );

    // edge detect on the synchronised copy only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tog_seen_reg <= 1'b0;
            o_pulse      <= 1'b0;
        end else begin
            tog_seen_reg <= tog_sync;
            o_pulse      <= tog_sync ^ tog_seen_reg;
        end
    end

endmodule

// [ssi_shift_in.sv]
// ssi_shift_in: synchronous serial receiver driving a clock pin and
// sampling a data pin into a result word.
// assumes: command side on i_mclk, pin side on the free-running i_lclk;
// commands are held stable by this block until their result returns.
`timescale 1ns/100ps
module ssi_shift_in (
    input  wire logic                          i_mclk,
    input  wire logic                          i_rstn,
    input  wire logic                          i_lclk,
    input  wire logic                          i_start,
    input  wire logic [1:0]                    i_mode,
    input  wire logic [ssi_pkg::BITS_W-1:0]    i_bits,
    input  wire logic [1:0]                    i_dest,
    input  wire logic                          i_chain,
    input  wire logic [ssi_pkg::PIN_SEL_W-1:0] i_dpin_sel,
    input  wire logic [ssi_pkg::PIN_SEL_W-1:0] i_cpin_sel,
    input  wire logic [ssi_pkg::NUM_PINS-1:0]  i_gpio_in,
    output logic                               o_busy,
    output logic                               o_result_valid,
    output logic      [ssi_pkg::DATA_W-1:0]    o_result,
    output logic      [ssi_pkg::NUM_PINS-1:0]  o_gpio_out,
    output logic      [ssi_pkg::NUM_PINS-1:0]  o_gpio_oe_n
);

    localparam int unsigned DW = ssi_pkg::DATA_W;
    localparam int unsigned NP = ssi_pkg::NUM_PINS;
    localparam int unsigned BW = ssi_pkg::BITS_W;
    localparam int unsigned PW = ssi_pkg::PIN_SEL_W;
    localparam int unsigned CW = ssi_pkg::CNT_W;

    // reset release, one copy per domain
    logic mrst_meta_reg;
    logic mrst_n;
    logic lrst_meta_reg;
    logic lrst_n;

    // command side
    logic          start_tog_reg;
    logic [1:0]    cmd_mode_reg;
    logic [BW-1:0] cmd_bits_reg;
    logic [1:0]    cmd_dest_reg;
    logic          cmd_chain_reg;
    logic [PW-1:0] cmd_dpin_reg;
    logic [PW-1:0] cmd_cpin_reg;
    logic          done_pulse;

    // link side
    ssi_pkg::ssi_lstate_t lstate_reg;
    ssi_pkg::ssi_lstate_t lstate_next;
    logic          start_pulse;
    logic          done_tog_reg;
    logic [CW-1:0] cnt_reg;
    logic [BW-1:0] bitcnt_reg;
    logic [BW-1:0] nbits_reg;
    logic [1:0]    mode_reg;
    logic [1:0]    dest_reg;
    logic          chain_reg;
    logic          in_chain_reg;
    logic [PW-1:0] dpin_reg;
    logic [PW-1:0] cpin_reg;
    logic          cpin_owned_reg;
    logic          clk_high_reg;
    logic          early_bit_reg;
    logic [DW-1:0] acc_reg;
    logic [DW-1:0] acc_next;
    logic [DW-1:0] lresult_reg;
    logic [NP-1:0] gpio_sync;
    logic          data_bit;
    logic          sample_bit;
    logic          cnt_done;
    logic          mode_late;
    logic          mode_lsb;

    // reset is asserted at once and released through two flops
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            mrst_meta_reg <= 1'b0;
            mrst_n        <= 1'b0;
        end else begin
            mrst_meta_reg <= 1'b1;
            mrst_n        <= mrst_meta_reg;
        end
    end

    always_ff @(posedge i_lclk or negedge i_rstn) begin
        if (!i_rstn) begin
            lrst_meta_reg <= 1'b0;
            lrst_n        <= 1'b0;
        end else begin
            lrst_meta_reg <= 1'b1;
            lrst_n        <= lrst_meta_reg;
        end
    end

    // command capture; fields stay frozen while busy so the link side
    // can read them safely once the start toggle has crossed
    always_ff @(posedge i_mclk or negedge mrst_n) begin
        if (!mrst_n) begin
            start_tog_reg <= 1'b0;
            cmd_mode_reg  <= ssi_pkg::MODE_MSB_FIRST_SAMPLE_EARLY;
            cmd_bits_reg  <= ssi_pkg::BITS_DEFAULT;
            cmd_dest_reg  <= ssi_pkg::DEST_BYTE;
            cmd_chain_reg <= 1'b0;
            cmd_dpin_reg  <= ssi_pkg::PIN_RESET;
            cmd_cpin_reg  <= ssi_pkg::PIN_RESET;
        end else if (i_start && !o_busy) begin
            start_tog_reg <= ~start_tog_reg;
            cmd_mode_reg  <= i_mode;
            cmd_bits_reg  <= ssi_pkg::ssi_bits(i_bits);
            cmd_dest_reg  <= i_dest;
            cmd_chain_reg <= i_chain;
            cmd_dpin_reg  <= i_dpin_sel;
            cmd_cpin_reg  <= i_cpin_sel;
        end
    end

    // busy from accepted start until the result has crossed back
    always_ff @(posedge i_mclk or negedge mrst_n) begin
        if (!mrst_n) begin
            o_busy <= 1'b0;
        end else if (done_pulse) begin
            o_busy <= 1'b0;
        end else if (i_start) begin
            o_busy <= 1'b1;
        end
    end

    // result word is stable in the link domain when its toggle arrives
    always_ff @(posedge i_mclk or negedge mrst_n) begin
        if (!mrst_n) begin
            o_result_valid <= 1'b0;
            o_result       <= ssi_pkg::DATA_RESET;
        end else begin
            o_result_valid <= done_pulse;
            if (done_pulse) begin
                o_result <= lresult_reg;
            end
        end
    end

    ssi_event_rx u_start_rx (
        .i_clk    (i_lclk),
        .i_rst_n  (lrst_n),
        .i_toggle (start_tog_reg),
        .o_pulse  (start_pulse)
    );

    ssi_event_rx u_done_rx (
        .i_clk    (i_mclk),
        .i_rst_n  (mrst_n),
        .i_toggle (done_tog_reg),
        .o_pulse  (done_pulse)
    );

    // pins come from outside, so all of them pass two flops
    ssi_sync #(.WIDTH(NP)) u_pin_sync (
        .i_clk   (i_lclk),
        .i_rst_n (lrst_n),
        .i_async (i_gpio_in),
        .o_sync  (gpio_sync)
    );

    assign mode_late  = mode_reg[ssi_pkg::MODE_LATE_POS];
    assign mode_lsb   = mode_reg[ssi_pkg::MODE_LSB_POS];
    assign data_bit   = gpio_sync[dpin_reg];
    assign cnt_done   = (clk_high_reg) ? (cnt_reg == ssi_pkg::PULSE_CNT_LAST)
                                       : (cnt_reg == ssi_pkg::LOW_CNT_LAST);
    assign sample_bit = mode_late ? data_bit : early_bit_reg;

    // first msb-first bit ends at bit nbits_reg-1, the top of the result
    always_comb begin
        acc_next = acc_reg;
        if (mode_lsb) begin
            acc_next = {sample_bit, acc_reg[DW-1:1]};
        end else begin
            acc_next = {acc_reg[DW-2:0], sample_bit};
        end
    end

    // link state transitions
    always_comb begin
        lstate_next = lstate_reg;
        case (lstate_reg)
            ssi_pkg::SSI_L_IDLE: begin
                if (start_pulse) begin
                    lstate_next = in_chain_reg ? ssi_pkg::SSI_L_BIT
                                               : ssi_pkg::SSI_L_SETUP;
                end
            end
            ssi_pkg::SSI_L_SETUP: begin
                if (cnt_done) begin
                    lstate_next = ssi_pkg::SSI_L_BIT;
                end
            end
            ssi_pkg::SSI_L_BIT: begin
                lstate_next = ssi_pkg::SSI_L_HIGH;
            end
            ssi_pkg::SSI_L_HIGH: begin
                if (cnt_done) begin
                    lstate_next = ssi_pkg::SSI_L_LOW;
                end
            end
            ssi_pkg::SSI_L_LOW: begin
                if (cnt_done) begin
                    lstate_next = (bitcnt_reg + 5'h01 == nbits_reg)
                                ? ssi_pkg::SSI_L_DONE : ssi_pkg::SSI_L_BIT;
                end
            end
            ssi_pkg::SSI_L_DONE: begin
                lstate_next = ssi_pkg::SSI_L_IDLE;
            end
            default: begin
                lstate_next = ssi_pkg::SSI_L_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            lstate_reg <= ssi_pkg::SSI_L_IDLE;
        end else begin
            lstate_reg <= lstate_next;
        end
    end

    // command copy into the link domain on the crossed start
    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            mode_reg  <= ssi_pkg::MODE_MSB_FIRST_SAMPLE_EARLY;
            nbits_reg <= ssi_pkg::BITS_DEFAULT;
            dest_reg  <= ssi_pkg::DEST_BYTE;
            chain_reg <= 1'b0;
            dpin_reg  <= ssi_pkg::PIN_RESET;
            cpin_reg  <= ssi_pkg::PIN_RESET;
        end else if (start_pulse && lstate_reg == ssi_pkg::SSI_L_IDLE) begin
            mode_reg  <= cmd_mode_reg;
            nbits_reg <= cmd_bits_reg;
            dest_reg  <= cmd_dest_reg;
            chain_reg <= cmd_chain_reg;
            dpin_reg  <= cmd_dpin_reg;
            cpin_reg  <= cmd_cpin_reg;
        end
    end

    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            cnt_reg      <= ssi_pkg::CNT_RESET;
            clk_high_reg <= 1'b0;
        end else if (lstate_reg == ssi_pkg::SSI_L_BIT) begin
            cnt_reg      <= ssi_pkg::CNT_RESET;
            clk_high_reg <= 1'b1;
        end else if (cnt_done || lstate_reg == ssi_pkg::SSI_L_IDLE ||
                     lstate_reg == ssi_pkg::SSI_L_DONE) begin
            cnt_reg      <= ssi_pkg::CNT_RESET;
            clk_high_reg <= 1'b0;
        end else begin
            cnt_reg      <= cnt_reg + 9'h001;
        end
    end

    // bit gathering; early sample is caught just before the pulse rises
    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            early_bit_reg <= 1'b0;
            bitcnt_reg    <= ssi_pkg::BITS_RESET;
            acc_reg       <= ssi_pkg::DATA_RESET;
        end else if (lstate_reg == ssi_pkg::SSI_L_IDLE) begin
            bitcnt_reg    <= ssi_pkg::BITS_RESET;
            acc_reg       <= ssi_pkg::DATA_RESET;
        end else if (lstate_reg == ssi_pkg::SSI_L_BIT) begin
            early_bit_reg <= data_bit;
        end else if (lstate_reg == ssi_pkg::SSI_L_LOW && cnt_done) begin
            acc_reg       <= acc_next;
            bitcnt_reg    <= bitcnt_reg + 5'h01;
        end
    end

    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            lresult_reg  <= ssi_pkg::DATA_RESET;
            done_tog_reg <= 1'b0;
            in_chain_reg <= 1'b0;
        end else if (lstate_reg == ssi_pkg::SSI_L_DONE) begin
            // lsb-first words fill from the top, so drop the unused bits
            lresult_reg  <= (mode_lsb ? (acc_reg >> (5'h10 - nbits_reg))
                                      : acc_reg)
                            & ssi_pkg::ssi_dest_mask(dest_reg);
            done_tog_reg <= ~done_tog_reg;
            in_chain_reg <= chain_reg;
        end
    end

    // pin drivers; the clock pin stays an output low after the transfer
    always_ff @(posedge i_lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            cpin_owned_reg <= 1'b0;
        end else if (lstate_reg == ssi_pkg::SSI_L_SETUP) begin
            cpin_owned_reg <= 1'b1;
        end
    end

    for (genvar p = 0; p < NP; p++) begin : g_pin
        logic is_clk;
        logic is_data;
        assign is_clk  = cpin_owned_reg && (cpin_reg == PW'(p));
        // data pin stays an input after the transfer as well
        assign is_data = (dpin_reg == PW'(p));
        always_ff @(posedge i_lclk or negedge lrst_n) begin
            if (!lrst_n) begin
                o_gpio_out[p]  <= 1'b0;
                o_gpio_oe_n[p] <= 1'b1;
            end else begin
                o_gpio_out[p]  <= is_clk && clk_high_reg &&
                                  (lstate_reg == ssi_pkg::SSI_L_HIGH);
                o_gpio_oe_n[p] <= ~(is_clk && !is_data) &&
                                  ~((lstate_reg == ssi_pkg::SSI_L_SETUP) &&
                                    (cpin_reg == PW'(p)) && !is_data);
            end
        end
    end

endmodule

// [ssi_shift_in_props.sv]
// ssi_shift_in_props: assertions bound to the serial shift-in top.
// assumes: pin selects held while busy; data pin never a past clock pin.
`timescale 1ns/100ps
module ssi_props (
    input wire logic        i_mclk,
    input wire logic        i_rstn,
    input wire logic        i_lclk,
    input wire logic        i_start,
    input wire logic [1:0]  i_dest,
    input wire logic [3:0]  i_dpin_sel,
    input wire logic [3:0]  i_cpin_sel,
    input wire logic        o_busy,
    input wire logic        o_result_valid,
    input wire logic [15:0] o_result,
    input wire logic [15:0] o_gpio_out,
    input wire logic [15:0] o_gpio_oe_n
);
    logic [1:0]  dest_q;
    logic [3:0]  dp_q;
    logic [3:0]  cp_q;
    logic [9:0]  hi_cnt;
    logic [9:0]  lo_cnt;
    logic [15:0] mask;
    wire         line = ~o_gpio_oe_n[cp_q] & o_gpio_out[cp_q];

    // command fields captured when a start is taken
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            dest_q <= 2'h0;
            dp_q   <= 4'h0;
            cp_q   <= 4'h0;
        end else if (i_start && !o_busy) begin
            dest_q <= i_dest;
            dp_q   <= i_dpin_sel;
            cp_q   <= i_cpin_sel;
        end
    end

    // high and low run lengths of the clock pin; low count saturates
    always_ff @(posedge i_lclk or negedge i_rstn) begin
        if (!i_rstn) begin
            hi_cnt <= 10'h000;
            lo_cnt <= 10'h000;
        end else if (line) begin
            hi_cnt <= hi_cnt + 10'h001;
            lo_cnt <= 10'h000;
        end else begin
            hi_cnt <= 10'h000;
            lo_cnt <= (lo_cnt == 10'h3ff) ? lo_cnt : lo_cnt + 10'h001;
        end
    end

    // widths kept by each destination size
    always_comb begin
        case (dest_q)
            2'h0:    mask = 16'h0001;
            2'h1:    mask = 16'h000f;
            2'h2:    mask = 16'h00ff;
            default: mask = 16'hffff;
        endcase
    end

    sequence s_accept;
        i_start && !o_busy;
    endsequence
    sequence s_pulse_end;
        $fell(line);
    endsequence
    sequence s_pulse_start;
        $rose(line);
    endsequence

    a_start_sets_busy: assert property (@(posedge i_mclk)
        disable iff (!i_rstn) s_accept |=> o_busy) else $error("no busy");
    a_valid_single: assert property (@(posedge i_mclk)
        disable iff (!i_rstn) o_result_valid |=> !o_result_valid)
        else $error("valid too long");
    a_valid_ends_busy: assert property (@(posedge i_mclk)
        disable iff (!i_rstn) o_result_valid |-> !o_busy)
        else $error("busy with valid");
    a_result_held: assert property (@(posedge i_mclk)
        disable iff (!i_rstn) !o_result_valid |-> $stable(o_result))
        else $error("result moved");
    a_result_masked: assert property (@(posedge i_mclk)
        disable iff (!i_rstn) o_result_valid |-> (o_result & ~mask) == 16'h0)
        else $error("result wider than destination");
    a_data_pin_input: assert property (@(posedge i_mclk)
        disable iff (!i_rstn) o_busy |-> o_gpio_oe_n[dp_q])
        else $error("data pin driven");
    a_pulse_width: assert property (@(posedge i_lclk)
        disable iff (!i_rstn) s_pulse_end |-> hi_cnt == 10'd438)
        else $error("bad pulse width");
    a_low_gap: assert property (@(posedge i_lclk)
        disable iff (!i_rstn) s_pulse_start |-> lo_cnt >= 10'd32)
        else $error("low time short");
    a_pulse_in_busy: assert property (@(posedge i_lclk)
        disable iff (!i_rstn) s_pulse_start |-> o_busy)
        else $error("pulse while idle");
    a_clk_low_first: assert property (@(posedge i_lclk)
        disable iff (!i_rstn) $fell(o_gpio_oe_n[cp_q]) |-> !o_gpio_out[cp_q])
        else $error("clock pin not low");
endmodule

bind ssi_shift_in ssi_props ssi_props_inst (.i_mclk, .i_rstn, .i_lclk,
    .i_start, .i_dest, .i_dpin_sel, .i_cpin_sel, .o_busy, .o_result_valid,
    .o_result, .o_gpio_out, .o_gpio_oe_n);

// [ssi_periph.sv]
// ssi_periph: behavioural shift register on the far side of the pins.
// assumes: pattern is loaded before each unchained transfer.
`timescale 1ns/100ps
module ssi_periph (
    input  wire logic [15:0] i_gpio_out,
    input  wire logic [15:0] i_gpio_oe_n,
    input  wire logic [3:0]  i_dpin,
    input  wire logic [3:0]  i_cpin,
    input  wire logic        i_load,
    input  wire logic [31:0] i_pattern,
    output logic      [15:0] o_gpio_in
);
    logic [31:0] sh_reg;
    wire         clk_line = ~i_gpio_oe_n[i_cpin] & i_gpio_out[i_cpin];

    always @(posedge clk_line or posedge i_load) begin
        if (i_load) begin
            sh_reg <= i_pattern;
        end else begin
            sh_reg <= {sh_reg[30:0], 1'b0};
        end
    end

    // other pins show the inverse, so a wrong pin select shows up
    always_comb begin
        o_gpio_in = {16{~sh_reg[31]}};
        o_gpio_in[i_dpin] = sh_reg[31];
    end
endmodule

// [test_ssi_shift_in.sv]
// test_ssi_shift_in: self-checking bench for the serial shift-in block.
// assumes: ssi_periph on the pins and the checker bound to the top.
`timescale 1ns/100ps
module test_ssi_shift_in;
    localparam logic [31:0] PAT = 32'hb4c3_9a5e;
    logic        i_mclk;
    logic        i_lclk;
    logic        i_rstn = 1'b0;
    logic        i_start = 1'b0;
    logic        i_chain = 1'b0;
    logic        ld = 1'b0;
    logic [1:0]  i_mode = 2'h0;
    logic [1:0]  i_dest = 2'h0;
    logic [4:0]  i_bits = 5'h00;
    logic [3:0]  i_dpin_sel = 4'h0;
    logic [3:0]  i_cpin_sel = 4'h0;
    wire  [15:0] i_gpio_in;
    logic        o_busy;
    logic        o_result_valid;
    logic [15:0] o_result;
    logic [15:0] o_gpio_out;
    logic [15:0] o_gpio_oe_n;
    int          errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          idx = 0;

    ssi_shift_in ssi_shift_in_inst (.i_mclk, .i_rstn, .i_lclk, .i_start,
        .i_mode, .i_bits, .i_dest, .i_chain, .i_dpin_sel, .i_cpin_sel,
        .i_gpio_in, .o_busy, .o_result_valid, .o_result, .o_gpio_out,
        .o_gpio_oe_n);
    ssi_periph ssi_periph_inst (.i_gpio_out(o_gpio_out),
        .i_gpio_oe_n(o_gpio_oe_n), .i_dpin(i_dpin_sel),
        .i_cpin(i_cpin_sel), .i_load(ld), .i_pattern(PAT),
        .o_gpio_in(i_gpio_in));

    // command clock, 4 ns
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    // link clock, 32 ns, offset so edges never line up
    initial begin
        i_lclk = 1'b0;
        #1.3;
        forever #16 i_lclk = ~i_lclk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // a hang is cut short well past the longest expected run
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            errors = errors + 1;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // expected word: bit k of the stream is PAT[31-idx-k], one later if late
    function automatic logic [15:0] expv(input logic [1:0] m, input int n,
        input int ix, input logic [1:0] d);
        logic [15:0] r;
        r = 16'h0000;
        for (int k = 0; k < n; k++) begin
            if (m[0]) begin
                r[k] = PAT[31 - ix - k - m[1]];
            end else begin
                r[n - 1 - k] = PAT[31 - ix - k - m[1]];
            end
        end
        return (d == 2'h0) ? r & 16'h0001 : (d == 2'h1) ? r & 16'h000f :
            (d == 2'h2) ? r & 16'h00ff : r;
    endfunction

    task automatic load();
        @(posedge i_mclk);
        ld <= 1'b1;
        @(posedge i_mclk);
        ld <= 1'b0;
        idx = 0;
    endtask

    // one command; start held past acceptance so busy must refuse it
    task automatic run(input logic [1:0] m, input logic [4:0] n,
        input logic [1:0] d, input logic ch, input logic [3:0] p);
        int w;
        int eb;
        eb = (n == 5'h00) ? 8 : int'(n);
        w = 0;
        @(posedge i_mclk);
        i_mode <= m;
        i_bits <= n;
        i_dest <= d;
        i_chain <= ch;
        i_cpin_sel <= p;
        i_dpin_sel <= 4'hf - p;
        i_start <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_start <= 1'b0;
        while (o_result_valid !== 1'b1 && w < 40000) begin
            @(posedge i_mclk);
            w = w + 1;
        end
        check({15'h0000, o_result_valid}, 16'h0001);
        check(o_result, expv(m, eb, idx, d));
        idx = idx + eb;
    endtask

    // every mode and every destination size, each on its own pin pair
    task automatic test_modes();
        for (int m = 0; m < 4; m++) begin
            load();
            run(2'(m), 5'h03, 2'h3 - 2'(m), 1'b0, 4'(m + 1));
            check({13'h0, o_gpio_oe_n[m + 1], o_gpio_out[m + 1],
                o_gpio_oe_n[14 - m]}, 16'h0001);
        end
        $display("test_modes done");
    endtask

    // one bit then a default-length nibble in one chained transfer
    task automatic test_chain();
        load();
        run(2'h0, 5'h01, 2'h3, 1'b1, 4'h1);
        run(2'h0, 5'h00, 2'h1, 1'b0, 4'h1);
        $display("test_chain done");
    endtask

    initial begin
        repeat (12) @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (8) @(posedge i_mclk);
        test_modes();
        test_chain();
        finish_test();
    end
endmodule
